// >>> pfsc_core.sv
/*
  pfsc_core: program counter, call stack and data stack control, and the
  operand fetch for the three addressing modes, of a small 8-bit core.
  Assumes: an instruction decoder issues one command at a time and holds off
  while busy_reg is high; reset-cause levels are steady around the reset.
*/
//
// Overview of operation
// - program counter is 14 bits and clears on any reset, fetch starts at zero.
// - sequential steps move only the low byte; page_advance bumps the upper six.
// - call and interrupt acknowledge save next address plus carry and zero.
// - interrupt_return restores counter and flags; plain return restores counter only.
// - no software path to the counter; stack bytes readable from SRAM address zero.
// - call_stack_pointer resets to zero, grows upward, loadable, never readable.
// - acknowledge disables interrupts, writes first byte, increments, writes second, increments.
// - interrupt_return decrements, reloads second, decrements, reloads first, then enables.
// - call adds two to call_stack_pointer; return subtracts two.
// - a 256-byte SRAM holds both stacks and the direct and indexed data operands.
// - push pre-decrements data_stack_pointer then writes; pop reads then post-increments.
// - data_stack_pointer resets to zero and wraps, first push lands at 0xff.
// - immediate mode uses the instruction's second byte directly as operand.
// - direct mode reads the SRAM byte at the instruction's address.
// - indexed mode reads at instruction byte plus offset_register.
// - both resets restore defaults, clear USB address, disable interrupts, zero pointers.
// - status bit 4 flags power-on reset, bit 6 flags watchdog reset.
// - reset pushes no return frame; execution starts at zero.
`timescale 1ns/1ps
module pfsc_core #(
  parameter int PCW   = pfsc_pkg::PC_W,
  parameter int DEPTH = pfsc_pkg::SRAM_DEPTH
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire logic                   clk_en,
  // reset cause, level, held through the reset and its release
  input  wire logic                   cause_power_on,
  input  wire logic                   cause_watchdog,
  // command from the instruction decoder
  input  wire logic                   cmd_valid,
  input  wire pfsc_pkg::pfsc_cmd_type cmd_op,
  input  wire logic [1:0]             cmd_len,
  input  wire logic [13:0]            cmd_target,
  input  wire logic [7:0]             cmd_byte,
  input  wire logic [7:0]             accumulator,
  input  wire logic [7:0]             offset_register,
  input  wire logic                   carry_in,
  input  wire logic                   zero_in,
  // software inspection of data SRAM
  input  wire logic [7:0]             sw_addr,
  output logic      [7:0]             sw_rdata,
  // program flow state
  output logic      [13:0]            program_counter_reg,
  output logic                        carry_reg,
  output logic                        zero_reg,
  output logic                        int_enable_reg,
  output logic                        busy_reg,
  // operand and pop data
  output logic      [7:0]             data_out_reg,
  output logic                        data_valid_reg,
  // status and system effects of reset
  output logic      [7:0]             status_reg,
  output logic                        usb_addr_clear_reg
);
  import pfsc_pkg::*;

  // the saved frame layout has exactly two bytes for the counter
  initial begin
    if (PCW != PC_W || DEPTH != SRAM_DEPTH) begin
      $error("pfsc_core: counter width and SRAM depth are fixed by the frame layout");
    end
  end

  // low-byte-only step: the page bits never move on a carry out
  function automatic logic [13:0] pc_step(input logic [13:0] pc, input logic [7:0] n);
    pc_step = {pc[13:8], pc[7:0] + n};
  endfunction : pc_step

  // high frame byte packs carry, zero and page bits
  function automatic logic [7:0] frame_hi(input logic [13:0] pc, input logic c,
                                          input logic z);
    frame_hi = {c, z, pc[13:8]};
  endfunction : frame_hi

  pfsc_state_type state_reg, state_next;
  logic [7:0]  csp_reg;          // call_stack_pointer, no read path
  logic [7:0]  dsp_reg;          // data_stack_pointer
  logic [7:0]  saved_hi_reg;
  logic        is_int_ret_reg;
  logic        opr_read_reg;
  logic        cause_pending_reg;
  logic [7:0]  mem_rdata;
  logic [13:0] target_reg;       // call or vector target, caught at the accept

  // decode of the accepted command
  wire accept     = clk_en && cmd_valid && (state_reg == PFSC_IDLE);
  wire do_advance = accept && (cmd_op == PFSC_ADVANCE);
  wire do_page    = accept && (cmd_op == PFSC_PAGE_ADV);
  wire do_jump    = accept && (cmd_op == PFSC_JUMP);
  wire do_call    = accept && (cmd_op == PFSC_CALL);
  wire do_ack     = accept && (cmd_op == PFSC_INT_ACK);
  wire do_ret     = accept && (cmd_op == PFSC_RET);
  wire do_interrupt_return    = accept && (cmd_op == PFSC_INT_RET);
  wire do_ldcsp   = accept && (cmd_op == PFSC_LOAD_CSP);
  wire do_lddsp   = accept && (cmd_op == PFSC_LOAD_DSP);
  wire do_push    = accept && (cmd_op == PFSC_PUSH);
  wire do_pop     = accept && (cmd_op == PFSC_POP);
  wire do_imm     = accept && (cmd_op == PFSC_OPR_IMM);
  wire do_dir     = accept && (cmd_op == PFSC_OPR_DIR);
  wire do_idx     = accept && (cmd_op == PFSC_OPR_IDX);
  wire do_save    = do_call || do_ack;
  wire do_restore = do_ret || do_interrupt_return;
  wire do_read    = do_pop || do_dir || do_idx;

  // stack pointer arithmetic, wrapping in eight bits
  wire [7:0] csp_up   = csp_reg + 8'h01;
  wire [7:0] csp_down = csp_reg - 8'h01;
  wire [7:0] dsp_down = dsp_reg - 8'h01;
  wire [7:0] dsp_up   = dsp_reg + 8'h01;
  wire [7:0] idx_addr = cmd_byte + offset_register;
  wire [7:0] hi_byte  = frame_hi(program_counter_reg, carry_reg, zero_reg);

  // single SRAM port: address and write selection
  wire       in_save_hi = (state_reg == PFSC_SAVE_HI);
  wire       in_rest_hi = (state_reg == PFSC_REST_HI);
  wire       in_rest_lo = (state_reg == PFSC_REST_LO);
  wire       mem_we     = clk_en && (do_save || do_push || in_save_hi);
  wire [7:0] mem_addr   = (do_save || in_save_hi)   ? csp_reg :
                          (do_restore || in_rest_hi) ? csp_down :
                          do_push                    ? dsp_down :
                          do_pop                     ? dsp_reg :
                          do_idx                     ? idx_addr :
                          cmd_byte;
  wire [7:0] mem_wdata  = do_save  ? program_counter_reg[7:0] :
                          do_push  ? accumulator :
                          hi_byte;

  // the restored frame as seen in the last restore cycle
  wire [13:0] rest_pc = {saved_hi_reg[PAGE_W-1:0], mem_rdata};

  pfsc_sram #(
    .DEPTH (SRAM_DEPTH),
    .AW    (SRAM_AW),
    .DW    (BYTE_W)
  ) u_sram (
    .clk_sys    (clk_sys),
    .clk_en     (clk_en),
    .core_we    (mem_we),
    .core_addr  (mem_addr),
    .core_wdata (mem_wdata),
    .core_rdata (mem_rdata),
    .sw_addr    (sw_addr),
    .sw_rdata   (sw_rdata)
  );

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PFSC_IDLE: begin
        if (do_save) begin
          state_next = PFSC_SAVE_HI;
        end else if (do_restore) begin
          state_next = PFSC_REST_HI;
        end
      end
      PFSC_SAVE_HI: state_next = PFSC_IDLE;
      PFSC_REST_HI: state_next = PFSC_REST_LO;
      PFSC_REST_LO: state_next = PFSC_IDLE;
      default:      state_next = PFSC_IDLE;
    endcase
  end

  // state, busy flag and return kind
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg      <= PFSC_IDLE;
      busy_reg       <= 1'b0;
      is_int_ret_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      busy_reg  <= (state_next != PFSC_IDLE);
      if (do_restore) begin
        is_int_ret_reg <= do_interrupt_return;
      end
    end
  end

  // program counter; reset loads zero and saves nothing on the stack
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      program_counter_reg <= PC_RESET;
    end else if (clk_en) begin
      if (do_advance) begin
        program_counter_reg <= pc_step(program_counter_reg, {6'h00, cmd_len});
      end else if (do_page) begin
        program_counter_reg <= {program_counter_reg[13:8] + 6'h01,
                                program_counter_reg[7:0] + 8'h01};
      end else if (do_jump) begin
        program_counter_reg <= cmd_target;
      end else if (in_save_hi) begin
        program_counter_reg <= target_reg;
      end else if (in_rest_lo) begin
        program_counter_reg <= rest_pc;
      end
    end
  end

  // flags take the datapath on advance and page_advance, the saved frame on an interrupt_return
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      carry_reg <= 1'b0;
      zero_reg  <= 1'b0;
    end else if (clk_en) begin
      if (in_rest_lo && is_int_ret_reg) begin
        carry_reg <= saved_hi_reg[FRAME_CARRY_BIT];
        zero_reg  <= saved_hi_reg[FRAME_ZERO_BIT];
      end else if (do_advance || do_page) begin
        carry_reg <= carry_in;
        zero_reg  <= zero_in;
      end
    end
  end

  // interrupt enable: off on acknowledge, on only after both bytes are back
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      int_enable_reg <= 1'b0;
    end else if (clk_en) begin
      if (do_ack) begin
        int_enable_reg <= 1'b0;
      end else if (in_rest_lo && is_int_ret_reg) begin
        int_enable_reg <= 1'b1;
      end
    end
  end

  // call stack pointer: +1 per saved byte, -1 per restored byte
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      csp_reg <= CSP_RESET;
    end else if (clk_en) begin
      if (do_ldcsp) begin
        csp_reg <= accumulator;
      end else if (do_save || in_save_hi) begin
        csp_reg <= csp_up;
      end else if (do_restore || in_rest_hi) begin
        csp_reg <= csp_down;
      end
    end
  end

  // first restored byte read is the high byte of the frame
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      saved_hi_reg <= 8'h00;
    end else if (clk_en && in_rest_hi) begin
      saved_hi_reg <= mem_rdata;
    end
  end

  // call target is caught at the accept so the decoder may move on at once
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      target_reg <= PC_RESET;
    end else if (clk_en && do_save) begin
      target_reg <= cmd_target;
    end
  end

  // data stack pointer
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dsp_reg <= DSP_RESET;
    end else if (clk_en) begin
      if (do_lddsp) begin
        dsp_reg <= accumulator;
      end else if (do_push) begin
        dsp_reg <= dsp_down;
      end else if (do_pop) begin
        dsp_reg <= dsp_up;
      end
    end
  end

  // operand and pop data: immediate answers a cycle sooner than a read
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      data_out_reg   <= 8'h00;
      data_valid_reg <= 1'b0;
      opr_read_reg   <= 1'b0;
    end else if (clk_en) begin
      opr_read_reg   <= do_read;
      data_valid_reg <= do_imm || opr_read_reg;
      if (do_imm) begin
        data_out_reg <= cmd_byte;
      end else if (opr_read_reg) begin
        data_out_reg <= mem_rdata;
      end
    end
  end

  // reset cause is caught by the first enabled edge after release
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      status_reg         <= STAT_RESET;
      cause_pending_reg  <= 1'b1;
      usb_addr_clear_reg <= 1'b1;
    end else if (clk_en) begin
      usb_addr_clear_reg <= 1'b0;
      if (cause_pending_reg) begin
        cause_pending_reg                <= 1'b0;
        status_reg[STAT_RUN_BIT]         <= 1'b1;
        status_reg[STAT_POR_BIT]         <= cause_power_on;
        status_reg[STAT_WDR_BIT]         <= cause_watchdog;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn || !clk_en);

  sequence s_save_frame;
    (mem_we && mem_addr == csp_reg) ##1 (mem_we && mem_addr == csp_reg);
  endsequence
  sequence s_restore_wait;
    (int_enable_reg == $past(int_enable_reg)) [*2];
  endsequence

  a_reset_state: assert property ($rose(resetn) |->
      program_counter_reg == PC_RESET && csp_reg == CSP_RESET &&
      dsp_reg == DSP_RESET && !int_enable_reg && !busy_reg)
    else $error("state not at defaults after reset");
  a_seq_page_hold: assert property (do_advance |=>
      program_counter_reg[13:8] == $past(program_counter_reg[13:8]))
    else $error("sequential step changed page bits");
  a_page_bump: assert property (do_page |=>
      program_counter_reg[13:8] == $past(program_counter_reg[13:8]) + 6'h01)
    else $error("page_advance did not bump page bits");
  a_ack_frame: assert property (do_ack |-> s_save_frame ##0 1'b1 ##1
      (!int_enable_reg && csp_reg == $past(csp_reg, 2) + 8'h02))
    else $error("acknowledge frame save wrong");
  a_call_csp: assert property (do_call |-> ##2
      csp_reg == $past(csp_reg, 2) + 8'h02)
    else $error("call did not add two");
  a_interrupt_return_order: assert property (do_interrupt_return |=> s_restore_wait ##1
      (int_enable_reg && csp_reg == $past(csp_reg, 3) - 8'h02))
    else $error("interrupt_return sequence wrong");
  a_ret_flags: assert property (do_ret |-> ##3
      (carry_reg == $past(carry_reg, 3) && zero_reg == $past(zero_reg, 3)))
    else $error("plain return changed flags");
  a_push_addr: assert property (do_push |-> mem_we &&
      mem_addr == dsp_reg - 8'h01 ##1 dsp_reg == $past(dsp_reg) - 8'h01)
    else $error("push not pre-decremented");
  a_idx_addr: assert property (do_idx |->
      mem_addr == cmd_byte + offset_register ##2 data_valid_reg)
    else $error("indexed address or timing wrong");
  a_imm_data: assert property (do_imm |=>
      data_valid_reg && data_out_reg == $past(cmd_byte))
    else $error("immediate operand wrong");

endmodule : pfsc_core

// >>> pfsc_core_tb.sv
/*
  pfsc_core_tb: self-checking bench for pfsc_core; commands go in one at a
  time through tasks and the results are compared with worked-out values.
  Assumes: pfsc_pkg, pfsc_sram, pfsc_core and pfsc_rom_model compiled first.
*/
`timescale 1ns/1ps
module pfsc_core_tb;
  import pfsc_pkg::*;
  // design inputs
  logic         clk_sys, resetn, clk_en, cause_power_on, cause_watchdog;
  logic         cmd_valid, carry_in, zero_in;
  pfsc_cmd_type cmd_op;
  logic [1:0]   cmd_len;
  logic [13:0]  cmd_target;
  logic [7:0]   cmd_byte, accumulator, offset_register, sw_addr;
  // design outputs and program memory
  logic [7:0]   sw_rdata, data_out_reg, status_reg, rom_byte;
  logic [13:0]  program_counter_reg;
  logic         carry_reg, zero_reg, int_enable_reg, busy_reg, data_valid_reg;
  logic         usb_addr_clear_reg, rom_reserved;
  int           fail_count, checks;

  pfsc_core dut (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
    .cause_power_on(cause_power_on), .cause_watchdog(cause_watchdog),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_len(cmd_len), .cmd_target(cmd_target),
    .cmd_byte(cmd_byte), .accumulator(accumulator), .offset_register(offset_register),
    .carry_in(carry_in), .zero_in(zero_in), .sw_addr(sw_addr), .sw_rdata(sw_rdata),
    .program_counter_reg(program_counter_reg), .carry_reg(carry_reg), .zero_reg(zero_reg),
    .int_enable_reg(int_enable_reg), .busy_reg(busy_reg), .data_out_reg(data_out_reg),
    .data_valid_reg(data_valid_reg), .status_reg(status_reg),
    .usb_addr_clear_reg(usb_addr_clear_reg)
  );
  pfsc_rom_model rom (.fetch_addr(program_counter_reg), .fetch_byte(rom_byte),
                      .fetch_reserved(rom_reserved));

  // 100 MHz system clock
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  // comparisons; every value is widened to 14 bits so one report format serves all
  task automatic cmp_word(input string name, input logic [13:0] exp, input logic [13:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_word
  task automatic cmp_bit(input string name, input logic exp, input logic got);
    cmp_word(name, {13'h0000, exp}, {13'h0000, got});
  endtask : cmp_bit
  task automatic pc_is(input logic [13:0] exp);
    cmp_word("program_counter_reg", exp, program_counter_reg);
  endtask : pc_is

  // inputs always move 1 ns after the rising edge
  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask : step
  // command is held until the edge that takes it, then released
  task automatic send(input pfsc_cmd_type op, input logic [13:0] tgt,
                      input logic [7:0] byt, input logic [7:0] acc);
    cmd_op      = op;
    cmd_target  = tgt;
    cmd_byte    = byt;
    accumulator = acc;
    cmd_valid   = 1'h1;
    step();
    cmd_valid   = 1'h0;
    cmd_target  = 14'h3fff;  // a taken command may change at once
  endtask : send
  // busy rises at the same edge that takes the command, so check it right after send
  task automatic run(input pfsc_cmd_type op, input logic [13:0] tgt, input logic [7:0] acc);
    logic seq_op;
    seq_op = (op == PFSC_CALL) || (op == PFSC_INT_ACK) ||
             (op == PFSC_RET) || (op == PFSC_INT_RET);
    send(op, tgt, 8'h00, acc);
    cmp_bit("busy_reg", seq_op, busy_reg);
    step();
    step();
    for (int i = 0; i < 8 && busy_reg !== 1'h0; i++) step();
    cmp_bit("busy_reg", 1'h0, busy_reg);
    step();
  endtask : run
  task automatic fetch_op(input pfsc_cmd_type op, input logic [7:0] byt, input logic [7:0] exp);
    send(op, 14'h0000, byt, 8'h00);
    for (int i = 0; i < 6 && data_valid_reg !== 1'h1; i++) step();
    cmp_bit("data_valid_reg", 1'h1, data_valid_reg);
    cmp_word("data_out_reg", {6'h00, exp}, {6'h00, data_out_reg});
    step();
  endtask : fetch_op
  task automatic ram_is(input logic [7:0] addr, input logic [7:0] exp);
    sw_addr = addr;
    step();
    step();
    cmp_word("sw_rdata", {6'h00, exp}, {6'h00, sw_rdata});
  endtask : ram_is
  // reset held 20 cycles; the cause levels stay up past the first enabled edge
  task automatic do_reset(input logic por, input logic watchdog_reset, input logic [7:0] exp_status);
    resetn         = 1'h0;
    cause_power_on = por;
    cause_watchdog = watchdog_reset;
    repeat (20) step();
    pc_is(14'h0000);
    cmp_bit("int_enable_reg", 1'h0, int_enable_reg);
    cmp_bit("usb_addr_clear_reg", 1'h1, usb_addr_clear_reg);
    resetn = 1'h1;
    step();
    cmp_word("status_reg", {6'h00, exp_status}, {6'h00, status_reg});
    cmp_bit("usb_addr_clear_reg", 1'h0, usb_addr_clear_reg);
    cause_power_on = 1'h0;
    cause_watchdog = 1'h0;
  endtask : do_reset

  task automatic give_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // main sequence; clk_en stays high since the built-in checks pause while it is low
  initial begin
    fail_count      = 0;
    checks          = 0;
    resetn          = 1'h0;
    clk_en          = 1'h1;
    cause_power_on  = 1'h0;
    cause_watchdog  = 1'h0;
    cmd_valid       = 1'h0;
    cmd_op          = PFSC_NOP;
    cmd_len         = 2'h2;
    cmd_target      = 14'h0000;
    cmd_byte        = 8'h00;
    accumulator     = 8'h00;
    offset_register = 8'h00;
    carry_in        = 1'h1;
    zero_in         = 1'h0;
    sw_addr         = 8'h00;
    do_reset(1'h1, 1'h0, 8'h11);
    // low byte wraps on its own; page_advance moves the upper six bits
    run(PFSC_ADVANCE, 14'h0000, 8'h00);
    pc_is(14'h0002);
    run(PFSC_JUMP, 14'h01fe, 8'h00);
    run(PFSC_ADVANCE, 14'h0000, 8'h00);
    pc_is(14'h0100);
    run(PFSC_PAGE_ADV, 14'h0000, 8'h00);
    pc_is(14'h0201);
    fetch_op(PFSC_OPR_IMM, rom_byte, rom_byte);
    cmp_bit("rom_reserved", 1'h0, rom_reserved);
    // call frame at 0x10 holds pc 0x0201 with carry set
    run(PFSC_LOAD_CSP, 14'h0000, 8'h10);
    run(PFSC_CALL, 14'h0234, 8'h00);
    pc_is(14'h0234);
    ram_is(8'h10, 8'h01);
    ram_is(8'h11, 8'h82);
    cmd_len  = 2'h1;
    carry_in = 1'h0;
    zero_in  = 1'h1;
    run(PFSC_ADVANCE, 14'h0000, 8'h00);
    run(PFSC_RET, 14'h0000, 8'h00);
    pc_is(14'h0201);
    cmp_bit("carry_reg", 1'h0, carry_reg);
    cmp_bit("zero_reg", 1'h1, zero_reg);
    // the frame must land at 0x10 again after the return took two off
    run(PFSC_INT_ACK, 14'h0008, 8'h00);
    ram_is(8'h10, 8'h01);
    ram_is(8'h11, 8'h42);
    carry_in = 1'h1;
    zero_in  = 1'h0;
    run(PFSC_ADVANCE, 14'h0000, 8'h00);
    run(PFSC_INT_RET, 14'h0000, 8'h00);
    pc_is(14'h0201);
    cmp_bit("carry_reg", 1'h0, carry_reg);
    cmp_bit("zero_reg", 1'h1, zero_reg);
    cmp_bit("int_enable_reg", 1'h1, int_enable_reg);
    run(PFSC_INT_ACK, 14'h0010, 8'h00);
    pc_is(14'h0010);
    cmp_bit("int_enable_reg", 1'h0, int_enable_reg);
    run(PFSC_INT_RET, 14'h0000, 8'h00);
    // data stack from reset wraps to 0xff, then a parked stack below 0x20
    run(PFSC_PUSH, 14'h0000, 8'ha5);
    ram_is(8'hff, 8'ha5);
    fetch_op(PFSC_POP, 8'h00, 8'ha5);
    run(PFSC_LOAD_DSP, 14'h0000, 8'h20);
    run(PFSC_PUSH, 14'h0000, 8'h11);
    run(PFSC_PUSH, 14'h0000, 8'h22);
    ram_is(8'h1f, 8'h11);
    fetch_op(PFSC_POP, 8'h00, 8'h22);
    fetch_op(PFSC_POP, 8'h00, 8'h11);
    fetch_op(PFSC_OPR_DIR, 8'h1f, 8'h11);
    // indexed: 0x10 plus 3 reaches 0x13, and 0xfe plus 1 reaches 0xff
    run(PFSC_LOAD_DSP, 14'h0000, 8'h14);
    run(PFSC_PUSH, 14'h0000, 8'h5c);
    offset_register = 8'h03;
    fetch_op(PFSC_OPR_IDX, 8'h10, 8'h5c);
    offset_register = 8'h01;
    fetch_op(PFSC_OPR_IDX, 8'hfe, 8'ha5);
    // mark 0x00 and 0x01 so a frame pushed by reset would show
    run(PFSC_LOAD_DSP, 14'h0000, 8'h02);
    run(PFSC_PUSH, 14'h0000, 8'h77);
    run(PFSC_PUSH, 14'h0000, 8'h66);
    do_reset(1'h0, 1'h1, 8'h41);
    ram_is(8'h00, 8'h66);
    ram_is(8'h01, 8'h77);
    run(PFSC_PUSH, 14'h0000, 8'h3c);
    ram_is(8'hff, 8'h3c);
    run(PFSC_CALL, 14'h0100, 8'h00);
    pc_is(14'h0100);
    ram_is(8'h00, 8'h00);
    ram_is(8'h01, 8'h00);
    give_verdict();
  end

  // the tests need some 180 cycles; 6000 cycles means a hang
  initial begin
    #60000;
    fail_count++;
    give_verdict();
  end
endmodule : pfsc_core_tb

// >>> pfsc_pkg.sv
/*
  pfsc_pkg: shared constants and types for the program-flow and stack-control
  block: widths, reset values, status bit positions, commands and the one-hot
  sequencer states.
  Assumes: the block runs on one 100 MHz clock with a synchronous reset.
*/
package pfsc_pkg;

  // widths and memory size
  localparam int PC_W       = 14;
  localparam int PAGE_W     = 6;
  localparam int BYTE_W     = 8;
  localparam int SRAM_DEPTH = 256;
  localparam int SRAM_AW    = 8;

  // reset values
  localparam logic [13:0] PC_RESET  = 14'h0000;
  localparam logic [7:0]  CSP_RESET = 8'h00;
  localparam logic [7:0]  DSP_RESET = 8'h00;

  // processor status and control bit positions
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_POR_BIT = 4;
  localparam int STAT_WDR_BIT = 6;
  localparam logic [7:0] STAT_RESET = 8'h00;

  // saved high byte of a call frame: carry, zero, then the page bits
  localparam int FRAME_CARRY_BIT = 7;
  localparam int FRAME_ZERO_BIT  = 6;

  // timing of the sequencer, in clock cycles from the accepting edge
  localparam int RETURN_CYCLES  = 3;
  localparam int CALL_CYCLES    = 2;
  localparam int OPERAND_CYCLES = 2;

  // commands from the instruction decoder
  typedef enum logic [3:0] {
    PFSC_NOP       = 4'h0,
    PFSC_ADVANCE   = 4'h1,
    PFSC_PAGE_ADV  = 4'h2,
    PFSC_JUMP      = 4'h3,
    PFSC_CALL      = 4'h4,
    PFSC_INT_ACK   = 4'h5,
    PFSC_RET       = 4'h6,
    PFSC_INT_RET   = 4'h7,
    PFSC_LOAD_CSP  = 4'h8,
    PFSC_LOAD_DSP  = 4'h9,
    PFSC_PUSH      = 4'ha,
    PFSC_POP       = 4'hb,
    PFSC_OPR_IMM   = 4'hc,
    PFSC_OPR_DIR   = 4'hd,
    PFSC_OPR_IDX   = 4'he
  } pfsc_cmd_type;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    PFSC_IDLE    = 4'b0001,
    PFSC_SAVE_HI = 4'b0010,
    PFSC_REST_HI = 4'b0100,
    PFSC_REST_LO = 4'b1000
  } pfsc_state_type;

endpackage : pfsc_pkg

// >>> pfsc_rom_model.sv
/*
  pfsc_rom_model: behavioural program memory that returns a fixed byte
  pattern for the address held in the program counter.
  Assumes: combinational read driven straight from program_counter_reg.
*/
`timescale 1ns/1ps
module pfsc_rom_model #(
  parameter int ROM_BYTES = 8192
) (
  // fetch address
  input  wire logic [13:0] fetch_addr,
  // fetched byte and a flag for the test-only area
  output logic      [7:0]  fetch_byte,
  output logic             fetch_reserved
);
  // past the populated space the byte follows the address, so nothing stale shows
  wire logic in_range = (int'(fetch_addr) < ROM_BYTES);
  assign fetch_reserved = in_range && (int'(fetch_addr) >= ROM_BYTES - 32);
  assign fetch_byte     = in_range ? (fetch_addr[7:0] ^ {2'h0, fetch_addr[13:8]} ^ 8'h5a)
                                   : ~fetch_addr[7:0];
endmodule : pfsc_rom_model

// >>> pfsc_sram.sv
/*
  pfsc_sram: the data SRAM in flip-flops, one write/read port for the core
  and one read-only port for software inspection; both reads are registered.
  Assumes: single clock, clock enable freezes all state.
*/
`timescale 1ns/1ps
module pfsc_sram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8,
  parameter int DW    = 8
) (
  // clock
  input  wire logic          clk_sys,
  input  wire logic          clk_en,
  // core port
  input  wire logic          core_we,
  input  wire logic [AW-1:0] core_addr,
  input  wire logic [DW-1:0] core_wdata,
  output logic      [DW-1:0] core_rdata,
  // software inspection port
  input  wire logic [AW-1:0] sw_addr,
  output logic      [DW-1:0] sw_rdata
);

  // an address wider than the array would silently alias
  initial begin
    if (DEPTH != (1 << AW)) begin
      $error("pfsc_sram: DEPTH must equal 2**AW");
    end
  end

  logic [DW-1:0] mem_reg [DEPTH];

  // contents carry no reset: software must not trust them after power-up
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (core_we) begin
        mem_reg[core_addr] <= core_wdata;
      end
      core_rdata <= mem_reg[core_addr];
      sw_rdata   <= mem_reg[sw_addr];
    end
  end

endmodule : pfsc_sram
